// ===== rtl/bpa_backplane.sv
// backplane panel logic: slot arbitration, reset switch, interrupt switch port
`timescale 1ns/100ps
`default_nettype none
`include "bpa_consts.svh"
module bpa_backplane
	import bpa_pkg::*;
#(
	parameter logic [23:0] DEBOUNCE_CYC = 24'(`BPA_DEBOUNCE_CYC)
)(
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire logic [7:0]                s_axi_awaddr,
	input  wire logic [2:0]                s_axi_awprot,
	input  wire logic                      s_axi_awvalid,
	output var  logic                      s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output var  logic                      s_axi_wready,
	output var  logic [1:0]                s_axi_bresp,
	output var  logic                      s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [7:0]                s_axi_araddr,
	input  wire logic [2:0]                s_axi_arprot,
	input  wire logic                      s_axi_arvalid,
	output var  logic                      s_axi_arready,
	output var  logic [31:0]               s_axi_rdata,
	output var  logic [1:0]                s_axi_rresp,
	output var  logic                      s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	input  wire logic [`BPA_SLOTS-1:0]     bus_req_n,
	input  wire logic [`BPA_SLOTS-1:0]     pri_out_n,
	output var  logic [`BPA_SLOTS-1:0]     pri_in_n,
	input  wire logic                      rst_switch_n,
	input  wire logic                      int_switch_n,
	output var  logic                      init_out,
	output var  logic                      init_oe,
	output var  logic [`BPA_INT_LINES-1:0] panel_interrupt_request,
	output var  logic [`BPA_INT_LINES-1:0] panel_interrupt_request_oe,
	input  wire logic [15:0]               io_addr,
	input  wire logic                      io_rd_n,
	input  wire logic                      io_wr_n,
	output var  logic                      dat0_out,
	output var  logic                      dat0_oe,
	output var  logic                      xack_out,
	output var  logic                      xack_oe
);
	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic [`BPA_SLOTS-1:0] req_s1_q;
	logic [`BPA_SLOTS-1:0] req_s2_q;
	logic [`BPA_SLOTS-1:0] pri_s1_q;
	logic [`BPA_SLOTS-1:0] pri_s2_q;
	logic [15:0]           adr_s1_q;
	logic [15:0]           adr_s2_q;
	logic [1:0]            cyc_s1_q;
	logic [1:0]            cyc_s2_q;
	logic                  wr_prev_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			req_s1_q <= '1;
			req_s2_q <= '1;
			pri_s1_q <= '1;
			pri_s2_q <= '1;
			adr_s1_q <= 16'h0000;
			adr_s2_q <= 16'h0000;
			cyc_s1_q <= 2'h3;
			cyc_s2_q <= 2'h3;
		end else begin
			req_s1_q <= bus_req_n;
			req_s2_q <= req_s1_q;
			pri_s1_q <= pri_out_n;
			pri_s2_q <= pri_s1_q;
			adr_s1_q <= io_addr;
			adr_s2_q <= adr_s1_q;
			cyc_s1_q <= {io_wr_n, io_rd_n};
			cyc_s2_q <= cyc_s1_q;
		end
	end

	// ---------------------------------------------------------------
	// configuration and status registers
	// ---------------------------------------------------------------
	logic [8:0]  ctrl_q;
	logic [15:0] port_q;
	logic        irq_q = 1'b0;
	logic        rst_pressed;
	logic        int_pressed;
	logic        int_prev_q;
	logic [2:0]  req_cnt;
	logic [31:0] status_w;

	always_comb begin
		req_cnt = 3'h0;
		for (int i = 0; i < `BPA_SLOTS; i++) begin
			req_cnt = req_cnt + {2'h0, ~req_s2_q[i]};
		end
	end

	assign status_w = {7'h00, req_cnt > 3'(`BPA_SERIAL_MAX), 2'h0, ~req_s2_q, 2'h0,
		pri_in_n == '1 ? 6'h00 : ~pri_in_n, 5'h00, int_pressed, rst_pressed, irq_q};

	// ---------------------------------------------------------------
	// register bus slave
	// ---------------------------------------------------------------
	logic        wr_take;
	logic        rd_take;
	logic        wr_ctrl;
	logic        wr_port;
	logic        wr_hit;
	logic        rd_hit;
	logic [31:0] wmask;
	logic [31:0] rd_word;
	logic [31:0] ctrl_wide;
	logic [31:0] port_wide;

	// both halves of a write are taken together, so either order works
	assign wr_take       = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
	assign s_axi_awready = wr_take;
	assign s_axi_wready  = wr_take;
	assign rd_take       = s_axi_arvalid & ~s_axi_rvalid;
	assign s_axi_arready = rd_take;

	assign wmask     = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
		{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
	assign ctrl_wide = {23'h000000, ctrl_q};
	assign port_wide = {16'h0000, port_q};
	assign wr_ctrl   = wr_take & (s_axi_awaddr == `BPA_OFF_CTRL);
	assign wr_port   = wr_take & (s_axi_awaddr == `BPA_OFF_PORT);
	assign wr_hit    = wr_ctrl | wr_port | (s_axi_awaddr == `BPA_OFF_STATUS);
	assign rd_hit    = (s_axi_araddr == `BPA_OFF_CTRL) | (s_axi_araddr == `BPA_OFF_PORT) |
		(s_axi_araddr == `BPA_OFF_STATUS);
	assign rd_word   = (s_axi_araddr == `BPA_OFF_CTRL) ? ctrl_wide :
		(s_axi_araddr == `BPA_OFF_PORT) ? port_wide :
		(s_axi_araddr == `BPA_OFF_STATUS) ? status_w : 32'h00000000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= `BPA_CTRL_RST; // R21
			port_q <= `BPA_PORT_RST; // R21
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= 9'((ctrl_wide & ~wmask) | (s_axi_wdata & wmask));
			end
			if (wr_port) begin
				port_q <= 16'((port_wide & ~wmask) | (s_axi_wdata & wmask));
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= BPA_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= BPA_RESP_OKAY;
			s_axi_rdata  <= 32'h00000000;
		end else begin
			if (wr_take) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? BPA_RESP_OKAY : BPA_RESP_DECERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (rd_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= rd_hit ? BPA_RESP_OKAY : BPA_RESP_DECERR;
				s_axi_rdata  <= rd_word;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// slot arbitration
	// ---------------------------------------------------------------
	bpa_arb_if ab ();

	assign ab.mode    = bpa_mode_e'(ctrl_q[`BPA_CTRL_PAR]);
	assign ab.tie_top = ctrl_q[`BPA_CTRL_TIE]; // R3
	assign ab.req     = ~req_s2_q; // R7
	assign ab.pri_out = ~pri_s2_q; // R5
	assign pri_in_n   = ~ab.grant; // R9

	bpa_arbiter u_arb (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ab      (ab.arb)
	);

	// ---------------------------------------------------------------
	// front panel switches
	// ---------------------------------------------------------------
	bpa_debounce #(.CYC(DEBOUNCE_CYC)) u_rst_db (
		.aclk    (aclk),
		.aresetn (aresetn),
		.raw_n   (rst_switch_n),
		.pressed (rst_pressed)
	);

	bpa_debounce #(.CYC(DEBOUNCE_CYC)) u_int_db (
		.aclk    (aclk),
		.aresetn (aresetn),
		.raw_n   (int_switch_n),
		.pressed (int_pressed)
	);

	// ---------------------------------------------------------------
	// interrupt port decode
	// ---------------------------------------------------------------
	logic       lo_match;
	logic       hi_match;
	logic       port_match;
	logic       rd_s;
	logic       wr_s;
	logic       wr_start;
	logic       int_rise;
	logic       irq_set;
	logic       irq_clr;
	logic [2:0] int_lvl;
	logic       int_en;

	assign lo_match   = adr_s2_q[7:0] == port_q[7:0]; // R20
	assign hi_match   = adr_s2_q[15:8] == port_q[15:8]; // R20
	assign port_match = lo_match & (hi_match | ~ctrl_q[`BPA_CTRL_DEC16]); // R19
	assign rd_s       = ~cyc_s2_q[0];
	assign wr_s       = ~cyc_s2_q[1];
	assign wr_start   = wr_s & ~wr_prev_q;
	assign int_rise   = int_pressed & ~int_prev_q; // R14
	assign irq_set    = int_rise;
	assign irq_clr    = wr_start & port_match; // R15
	assign int_lvl    = ctrl_q[`BPA_CTRL_LVL_HI:`BPA_CTRL_LVL_LO];
	assign int_en     = ctrl_q[`BPA_CTRL_INTEN];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_prev_q  <= 1'b0;
			int_prev_q <= 1'b0;
		end else begin
			wr_prev_q  <= wr_s;
			int_prev_q <= int_pressed;
		end
	end

	// no reset here on purpose; a fresh edge must win over a clear
	always_ff @(posedge aclk) begin
		irq_q <= irq_set | (irq_q & ~irq_clr); // R14 R15 R18
	end

	// ---------------------------------------------------------------
	// open drain and bus drivers
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			init_oe  <= 1'b0;
			dat0_oe  <= 1'b0;
			dat0_out <= 1'b1;
			xack_oe  <= 1'b0;
		end else begin
			init_oe  <= rst_pressed & ctrl_q[`BPA_CTRL_RSTEN]; // R11 R12
			dat0_oe  <= rd_s & port_match & ctrl_q[`BPA_CTRL_STSEN]; // R16 R17
			dat0_out <= ~irq_q; // R16
			xack_oe  <= (rd_s | wr_s) & port_match; // R22
		end
	end

	assign init_out = 1'b0;
	assign xack_out = 1'b0;

	for (genvar k = 0; k < `BPA_INT_LINES; k++) begin : g_int
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				panel_interrupt_request_oe[k] <= 1'b0;
			end else begin
				panel_interrupt_request_oe[k] <= irq_q & int_en & (int_lvl == 3'(k)); // R13
			end
		end
		assign panel_interrupt_request[k] = 1'b0;
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_port_write;
		wr_start && port_match && !irq_set;
	endsequence
	sequence s_reset_press;
		rst_pressed && ctrl_q[`BPA_CTRL_RSTEN];
	endsequence

	irq_clear_write_a: assert property (s_port_write |=> !irq_q) // R15
		else $error("port write did not clear interrupt flip-flop");
	irq_set_edge_a: assert property (int_rise |=> irq_q [*2] or (irq_q ##1 $past(irq_clr))) // R14
		else $error("interrupt flip-flop not held after switch edge");
	irq_hold_a: assert property (irq_q && !irq_clr |=> irq_q) // R14
		else $error("interrupt flip-flop dropped without a port write");
	init_drive_a: assert property (s_reset_press ##1 s_reset_press |-> init_oe) // R11
		else $error("debounced reset not driven to bus init");
	init_blocked_a: assert property (!ctrl_q[`BPA_CTRL_RSTEN] |=> !init_oe) // R12
		else $error("bus init driven without reset enable");
	status_read_a: assert property (dat0_oe |-> $past(ctrl_q[`BPA_CTRL_STSEN]) && $past(port_match)
		&& dat0_out == !$past(irq_q)) // R16 R17
		else $error("data bit 0 driven wrongly");
	decode_width_a: assert property (xack_oe |-> $past(adr_s2_q[7:0]) == $past(port_q[7:0])
		&& ($past(adr_s2_q[15:8]) == $past(port_q[15:8]) || !$past(ctrl_q[`BPA_CTRL_DEC16]))) // R19
		else $error("acknowledge on an address that does not match");
	ack_match_a: assert property ((rd_s || wr_s) && port_match |=> xack_oe) // R22
		else $error("matching I/O cycle not acknowledged");
	int_route_a: assert property (|panel_interrupt_request_oe |-> $onehot(panel_interrupt_request_oe)
		&& panel_interrupt_request_oe[$past(int_lvl)] && $past(int_en)) // R13
		else $error("panel interrupt on an unselected line");
	port_default_a: assert property (disable iff (1'b0) !aresetn |=> port_q == 16'h07ff
		&& ctrl_q[`BPA_CTRL_DEC16]) // R21
		else $error("port address not at factory default after reset");
endmodule
`default_nettype wire

// ===== rtl/bpa_consts.svh
// constants for the backplane arbiter and panel logic
// Overview of operation
// (R1) Serial mode chains each slot's priority output to next slot's input; three masters maximum.
// (R2) Fixed priority: slot 1 highest down to slot 6 lowest, both schemes.
// (R3) Serial mode: top priority slot input is tied active by shunt or jumper.
// (R4) Serial mode: every slot passes the chain on, by master logic or bypass.
// (R5) Serial mode: each master drives its priority output for the next slot.
// (R6) On-board input grounding allowed only in serial mode at top position.
// (R7) Parallel mode accepts requests from all six slots, fixed priority order.
// (R8) Parallel mode grants only the highest requesting slot; others see none.
// (R9) Parallel mode drives one dedicated grant output per slot.
// (R10) Parallel mode: no master holds its priority input permanently grounded.
// (R11) Reset switch is debounced and drives bus init when enabled.
// (R12) Without the reset enable, the reset switch leaves bus init alone.
// (R13) Panel interrupt is non-vectored, routed to one selected line of eight, or none.
// (R14) Interrupt flip-flop sets on leading edge of debounced switch, stays set.
// (R15) Any I/O write to the port address clears the flip-flop, data ignored.
// (R16) I/O read of the port returns flip-flop state on data bit 0.
// (R17) Flip-flop drives data bit 0 only with status read enabled.
// (R18) Flip-flop is not cleared by reset; software clears it at start.
// (R19) Sixteen-bit decode compares upper address byte too; else lower byte only.
// (R20) Each address bit matches one when its select bit is set, else zero.
// (R21) Port defaults to sixteen-bit decoding at address 07ff.
// (R22) Port acknowledges every matching I/O read or write.
`ifndef BPA_CONSTS_SVH
`define BPA_CONSTS_SVH

`define BPA_SLOTS        6
`define BPA_SERIAL_MAX   3
`define BPA_INT_LINES    8
`define BPA_CLK_MHZ      100
`define BPA_DEBOUNCE_US  5000
`define BPA_DEBOUNCE_CYC (`BPA_DEBOUNCE_US * `BPA_CLK_MHZ)

`define BPA_OFF_CTRL     8'h00
`define BPA_OFF_PORT     8'h04
`define BPA_OFF_STATUS   8'h08

`define BPA_CTRL_PAR     0
`define BPA_CTRL_RSTEN   1
`define BPA_CTRL_STSEN   2
`define BPA_CTRL_DEC16   3
`define BPA_CTRL_INTEN   4
`define BPA_CTRL_LVL_LO  5
`define BPA_CTRL_LVL_HI  7
`define BPA_CTRL_TIE     8
`define BPA_CTRL_RST     9'h00f
`define BPA_PORT_RST     16'h07ff

`define BPA_ST_IRQ       0
`define BPA_ST_RSTSW     1
`define BPA_ST_INTSW     2
`define BPA_ST_GNT_LO    8
`define BPA_ST_REQ_LO    16
`define BPA_ST_OVER      24

`endif

// ===== rtl/bpa_pkg.sv
// types shared by the backplane arbiter and panel logic
package bpa_pkg;
	typedef enum logic {
		BPA_SERIAL   = 1'b0,
		BPA_PARALLEL = 1'b1
	} bpa_mode_e;
	typedef enum logic [1:0] {
		BPA_RESP_OKAY   = 2'b00,
		BPA_RESP_DECERR = 2'b11
	} bpa_resp_e;
endpackage

// ===== rtl/bpa_arb_if.sv
// carrier between the panel top and the slot arbiter
`timescale 1ns/100ps
`default_nettype none
`include "bpa_consts.svh"
interface bpa_arb_if;
	import bpa_pkg::*;
	bpa_mode_e              mode;
	logic                   tie_top;
	logic [`BPA_SLOTS-1:0]  req;
	logic [`BPA_SLOTS-1:0]  pri_out;
	logic [`BPA_SLOTS-1:0]  grant;
	modport arb (input mode, input tie_top, input req, input pri_out, output grant);
	modport ctl (output mode, output tie_top, output req, output pri_out, input grant);
endinterface
`default_nettype wire

// ===== rtl/bpa_debounce.sv
// synchroniser and debouncer for one front panel switch
`timescale 1ns/100ps
`default_nettype none
module bpa_debounce #(
	parameter logic [23:0] CYC = 24'd1
)(
	input  wire logic  aclk,
	input  wire logic  aresetn,
	input  wire logic  raw_n,
	output var  logic  pressed
);
	logic        sync1_q;
	logic        sync2_q;
	logic        stable_q;
	logic [23:0] cnt_q;
	logic        differs;
	logic        expired;

	assign differs = sync2_q != stable_q;
	assign expired = cnt_q == CYC - 24'd1;
	assign pressed = ~stable_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
		end else begin
			sync1_q <= raw_n;
			sync2_q <= sync1_q;
		end
	end

	// a bounce back to the old level restarts the wait
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q    <= 24'h000000;
			stable_q <= 1'b1;
		end else if (!differs) begin
			cnt_q    <= 24'h000000;
		end else if (expired) begin
			cnt_q    <= 24'h000000;
			stable_q <= sync2_q;
		end else begin
			cnt_q    <= cnt_q + 24'h000001;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	stable_after_wait_a: assert property ($changed(stable_q) |-> $past(expired) && $past(differs)) // R11
		else $error("switch level changed before debounce time");
endmodule
`default_nettype wire

// ===== rtl/bpa_arbiter.sv
// fixed priority slot arbiter, serial chain or parallel grant
`timescale 1ns/100ps
`default_nettype none
`include "bpa_consts.svh"
module bpa_arbiter
	import bpa_pkg::*;
(
	input  wire logic  aclk,
	input  wire logic  aresetn,
	bpa_arb_if.arb     ab
);
	logic [`BPA_SLOTS:0]   above;
	logic [`BPA_SLOTS-1:0] chain;
	logic [`BPA_SLOTS-1:0] grant_d;
	logic [`BPA_SLOTS-1:0] grant_q;

	assign above[0] = 1'b0;
	assign chain    = {ab.pri_out[`BPA_SLOTS-2:0], ab.tie_top}; // R1 R3 R4
	assign ab.grant = grant_q;

	// slot index 0 is the top priority slot, so lower index wins
	for (genvar i = 0; i < `BPA_SLOTS; i++) begin : g_slot
		assign above[i+1] = above[i] | ab.req[i]; // R2
		assign grant_d[i] = (ab.mode == BPA_PARALLEL) ? (ab.req[i] & ~above[i]) : chain[i]; // R7 R8
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			grant_q <= '0;
		end else begin
			grant_q <= grant_d; // R9
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	for (genvar i = 0; i < `BPA_SLOTS; i++) begin : g_chk
		par_grant_winner_a: assert property ( // R8
			$past(ab.mode) == BPA_PARALLEL && grant_q[i] |-> $past(ab.req[i]) && !$past(above[i]))
			else $error("parallel grant given to a slot that is not the winner");
	end
	par_grant_single_a: assert property ( // R8
		$past(ab.mode) == BPA_PARALLEL && $past(|ab.req) |-> $onehot(grant_q))
		else $error("parallel grant not exactly one slot");
	ser_chain_pass_a: assert property ( // R1
		$past(ab.mode) == BPA_SERIAL |-> grant_q[1] == $past(ab.pri_out[0]))
		else $error("serial chain not passed to next slot");
endmodule
`default_nettype wire

// ===== sim/bpa_slots.sv
// slot board model: request pins and priority chain pass-through
`timescale 1ns/100ps
`default_nettype none
module bpa_slots (
	input  wire logic [5:0] want,
	input  wire logic [5:0] pri_in_n,
	output var  logic [5:0] bus_req_n,
	output var  logic [5:0] pri_out_n
);
	// boards never ground their own priority input, the backplane tie is used
	assign bus_req_n = ~want;
	// a requesting master holds the chain, idle boards and bypasses pass it on
	assign pri_out_n = pri_in_n | want;
endmodule
`default_nettype wire

// ===== sim/backplane_arbiter_panel_logic_bench.sv
// self-checking bench for the backplane arbiter and panel logic
`timescale 1ns/100ps
`default_nettype none
`include "bpa_consts.svh"
module backplane_arbiter_panel_logic_bench;
	import bpa_pkg::*;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [5:0]  want = 6'h00;
	logic [5:0]  bus_req_n, pri_out_n, pri_in_n;
	logic        rst_switch_n = 1'b1;
	logic        int_switch_n = 1'b1;
	logic        init_out, init_oe, dat0_out, dat0_oe, xack_out, xack_oe;
	logic [7:0]  irq_out, irq_oe;
	logic [15:0] io_addr = 16'h0;
	logic        io_rd_n = 1'b1;
	logic        io_wr_n = 1'b1;
	logic [31:0] d;
	int          n_errors = 0;
	int          cmp_count = 0;

	always #5 aclk = ~aclk;

	bpa_backplane #(.DEBOUNCE_CYC(24'd4)) DUT (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .bus_req_n(bus_req_n), .pri_out_n(pri_out_n),
		.pri_in_n(pri_in_n), .rst_switch_n(rst_switch_n), .int_switch_n(int_switch_n),
		.init_out(init_out), .init_oe(init_oe), .panel_interrupt_request(irq_out),
		.panel_interrupt_request_oe(irq_oe), .io_addr(io_addr), .io_rd_n(io_rd_n),
		.io_wr_n(io_wr_n), .dat0_out(dat0_out), .dat0_oe(dat0_oe),
		.xack_out(xack_out), .xack_oe(xack_oe)
	);

	bpa_slots slots (.want(want), .pri_in_n(pri_in_n), .bus_req_n(bus_req_n),
		.pri_out_n(pri_out_n));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic complete_run;
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do @(posedge aclk); while (awready !== 1'b1);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		bready <= 1'b1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, bresp});
	endtask

	task automatic axr(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		v = rdata;
		rready <= 1'b0;
		chk("rresp", {30'h0, er}, {30'h0, rresp});
	endtask

	// address is set a cycle ahead of the strobe and held while it is low
	task automatic io(input logic [15:0] a, input logic wr, input logic ea, input logic [1:0] ed);
		@(posedge aclk);
		io_addr <= a;
		@(posedge aclk);
		if (wr) io_wr_n <= 1'b0;
		else io_rd_n <= 1'b0;
		repeat (6) @(posedge aclk);
		chk("xack_oe", ea, xack_oe);
		chk("xack_out", 1'b0, xack_out);
		if (!wr) chk("dat0_oe", ed[1], dat0_oe);
		if (!wr && ed[1]) chk("dat0_out", ed[0], dat0_out);
		io_wr_n <= 1'b1;
		io_rd_n <= 1'b1;
		repeat (6) @(posedge aclk);
	endtask

	function automatic logic [5:0] gnt_n(input logic [5:0] w);
		gnt_n = 6'h3f;
		for (int i = 5; i >= 0; i--) if (w[i]) gnt_n = ~(6'h01 << i);
	endfunction

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs;
		axr(`BPA_OFF_CTRL, BPA_RESP_OKAY, d);
		chk("ctrl", 32'h0000000f, d);
		axr(`BPA_OFF_PORT, BPA_RESP_OKAY, d);
		chk("port", 32'h000007ff, d);
		axr(8'h0c, BPA_RESP_DECERR, d);
		axw(8'h0c, 32'h0, BPA_RESP_DECERR);
		io(16'h07ff, 1'b1, 1'b1, 2'b00);
		io(16'h07ff, 1'b0, 1'b1, 2'b11);
		io(16'h17ff, 1'b0, 1'b0, 2'b00);
	endtask

	task automatic t_parallel;
		logic [5:0] pats [6] = '{6'h00, 6'h3f, 6'h20, 6'h28, 6'h06, 6'h30};
		foreach (pats[i]) begin
			want <= pats[i];
			repeat (8) @(posedge aclk);
			chk("grant", gnt_n(pats[i]), pri_in_n);
		end
	endtask

	task automatic t_serial;
		axw(`BPA_OFF_CTRL, 32'h10e, BPA_RESP_OKAY);
		want <= 6'h04;
		repeat (30) @(posedge aclk);
		chk("chain", 6'h38, pri_in_n);
		want <= 6'h0f;
		repeat (30) @(posedge aclk);
		axr(`BPA_OFF_STATUS, BPA_RESP_OKAY, d);
		chk("over", 1'b1, d[`BPA_ST_OVER]);
		chk("req_stat", 6'h0f, d[21:16]);
		chk("gnt_stat", 6'h01, d[13:8]);
		axw(`BPA_OFF_CTRL, 32'h00e, BPA_RESP_OKAY);
		want <= 6'h00;
		repeat (30) @(posedge aclk);
		chk("untied", 6'h3f, pri_in_n);
		axw(`BPA_OFF_CTRL, 32'h00f, BPA_RESP_OKAY);
	endtask

	task automatic t_reset_sw;
		for (int en = 1; en >= 0; en--) begin
			axw(`BPA_OFF_CTRL, 32'h00d | (en << 1), BPA_RESP_OKAY);
			rst_switch_n <= 1'b0;
			repeat (20) @(posedge aclk);
			chk("init_oe", en[0], init_oe);
			chk("init_out", 1'b0, init_out);
			axr(`BPA_OFF_STATUS, BPA_RESP_OKAY, d);
			chk("rst_sw", 1'b1, d[`BPA_ST_RSTSW]);
			rst_switch_n <= 1'b1;
			repeat (20) @(posedge aclk);
			chk("init_oe", 1'b0, init_oe);
		end
	endtask

	task automatic t_irq;
		int_switch_n <= 1'b0;
		repeat (20) @(posedge aclk);
		axr(`BPA_OFF_STATUS, BPA_RESP_OKAY, d);
		chk("int_sw", 1'b1, d[`BPA_ST_INTSW]);
		chk("irq_set", 1'b1, d[`BPA_ST_IRQ]);
		int_switch_n <= 1'b1;
		repeat (20) @(posedge aclk);
		for (int l = 0; l < 8; l++) begin
			axw(`BPA_OFF_CTRL, 32'h01f | (l << 5), BPA_RESP_OKAY);
			repeat (4) @(posedge aclk);
			chk("irq_oe", 8'h01 << l, irq_oe);
		end
		axw(`BPA_OFF_CTRL, 32'h00f, BPA_RESP_OKAY);
		repeat (4) @(posedge aclk);
		chk("irq_oe", 8'h00, irq_oe);
		chk("irq_out", 8'h00, irq_out);
		io(16'h07ff, 1'b0, 1'b1, 2'b10);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		axr(`BPA_OFF_STATUS, BPA_RESP_OKAY, d);
		chk("irq_ff", 1'b1, d[`BPA_ST_IRQ]);
		io(16'h07ff, 1'b1, 1'b1, 2'b00);
		io(16'h07ff, 1'b0, 1'b1, 2'b11);
		axw(`BPA_OFF_CTRL, 32'h00b, BPA_RESP_OKAY);
		io(16'h07ff, 1'b0, 1'b1, 2'b00);
	endtask

	task automatic t_decode;
		axw(`BPA_OFF_CTRL, 32'h007, BPA_RESP_OKAY);
		io(16'h17ff, 1'b0, 1'b1, 2'b11);
		axw(`BPA_OFF_PORT, 32'h0000a512, BPA_RESP_OKAY);
		io(16'h0012, 1'b0, 1'b1, 2'b11);
		io(16'h0013, 1'b0, 1'b0, 2'b00);
		axw(`BPA_OFF_CTRL, 32'h00f, BPA_RESP_OKAY);
		io(16'ha512, 1'b1, 1'b1, 2'b00);
		io(16'h0512, 1'b0, 1'b0, 2'b00);
	endtask

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs;
		t_parallel;
		t_serial;
		t_reset_sw;
		t_irq;
		t_decode;
		complete_run;
	end

	// the whole sequence needs well under a thousand cycles; this leaves wide margin
	initial begin
		repeat (20000) @(posedge aclk);
		n_errors++;
		complete_run;
	end
endmodule
`default_nettype wire
